// >>> logic/supervisor_pkg.sv
// Purpose: shared constants and types of the battery state supervisor logic
// Assumes: 200 MHz clock; all intervals are built from one 1 ms tick
// Notes: debounce, manual reset and power-on reset keep the 1 : 8 : 32 ratio
package supervisor_pkg;

  localparam int CLK_PERIOD_PS = 5000;
  localparam int TICK_PERIOD_MS = 1;
  // 1e9 ps per ms stays below 2**31
  localparam int TICK_CYCLES = TICK_PERIOD_MS * 1000000000 / CLK_PERIOD_PS;

  localparam int DEBOUNCE_MS = 25;
  localparam int MR_RATIO = 8;
  localparam int POR_RATIO = 32;
  localparam int MR_MS = DEBOUNCE_MS * MR_RATIO;
  localparam int POR_MS = DEBOUNCE_MS * POR_RATIO;

  localparam int CNT_W = 10;
  localparam logic [CNT_W-1:0] DEB_TICKS = CNT_W'(DEBOUNCE_MS / TICK_PERIOD_MS);
  localparam logic [CNT_W-1:0] MR_TICKS = CNT_W'(MR_MS / TICK_PERIOD_MS);
  localparam logic [CNT_W-1:0] POR_TICKS = CNT_W'(POR_MS / TICK_PERIOD_MS);
  localparam logic [CNT_W-1:0] CNT_MAX = 10'h3FF;

  // comparator results: 1 means the sensed level is above the reference
  typedef struct packed {
    logic battery_ok;
    logic low_battery;
    logic dead_battery;
  } sense_t;

  typedef enum logic [2:0] {
    ST_WAIT_OK = 3'h0,
    ST_POR = 3'h1,
    ST_RUN = 3'h2,
    ST_MR_DEBOUNCE = 3'h3,
    ST_MR_PULSE = 3'h4,
    ST_DEAD = 3'h5
  } sup_state_t;

endpackage

// >>> logic/tick_divider.sv
// Purpose: common timebase, one-cycle tick every TICK_CYCLES clocks
// Assumes: TICK_CYCLES is at least 2
// Notes: every supervisor interval counts these ticks
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
  parameter int TICK_CYCLES = 200000
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  output logic tick_out
);
  localparam int W = $clog2(TICK_CYCLES);
  localparam logic [W-1:0] LAST = W'(TICK_CYCLES - 1);

  logic [W-1:0] cnt;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= '0;
      tick_out <= 1'b0;
    end else if (cnt == LAST) begin
      cnt <= '0;
      tick_out <= 1'b1;
    end else begin
      cnt <= cnt + 1'b1;
      tick_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> logic/battery_state_supervisor_logic.sv
// Purpose: sequencing logic of a battery supervisor driving three open-drain flags
// Assumes: comparator results arrive asynchronously, 1 = above reference
// Notes: open-drain pins are driven low while the matching _oe_out is high
//
// Summary of operation
// - fresh battery: hold system reset low at least 700 ms before release
// - low battery alert follows the low battery comparator, never latched
// - dead battery asserts reset and power-off flag, latched until new reset cycle
// - battery-ok rising starts reset cycle: reset 700 ms min, power-off flag cleared
// - battery-ok pulled low is debounced, then reset asserted 175 ms minimum
// - all three outputs are active-low open-drain, driven only when asserted
// - debounce is one 32nd of power-on and one 8th of manual pulse
// - manual pulse 175 to 300 ms, debounce 22 to 38 ms
`timescale 1ns/1ps
`default_nettype none
module battery_state_supervisor_logic import supervisor_pkg::*; #(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic battery_ok_sense_manual_reset_in,
  input wire logic low_battery_sense_in,
  input wire logic dead_battery_sense_in,
  output logic sys_reset_n_out,
  output logic sys_reset_oe_out,
  output logic low_battery_alert_n_out,
  output logic low_battery_alert_oe_out,
  output logic power_off_flag_n_out,
  output logic power_off_flag_oe_out
);

  ////////////////////////////////////////////////////////////////////////////////
  logic [1:0] rst_pipe;
  logic rst_n;
  sense_t sense_meta;
  sense_t sense_sync;
  logic ok_prev;
  logic tick;
  sup_state_t state;
  sup_state_t next_state;
  logic [CNT_W-1:0] tick_count;
  logic power_off_latch;
  logic pin_low;
  logic ok_rise;
  logic dead_low;

  function automatic logic span_done(input logic [CNT_W-1:0] cnt,
                                     input logic [CNT_W-1:0] limit,
                                     input logic tk);
    return (cnt >= limit) || (tk && (cnt == limit - 10'h001));
  endfunction

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // only sense_sync is read; sense_meta is the metastability stage
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      // low and dead start above reference: no false alert or latch after reset
      // battery-ok starts low, so a battery already present reads as a fresh rise
      sense_meta <= 3'h3;
      sense_sync <= 3'h3;
      ok_prev <= 1'b0;
    end else begin
      sense_meta <= {battery_ok_sense_manual_reset_in, low_battery_sense_in,
                     dead_battery_sense_in};
      sense_sync <= sense_meta;
      ok_prev <= sense_sync.battery_ok;
    end
  end

  assign ok_rise = sense_sync.battery_ok && !ok_prev;
  assign dead_low = !sense_sync.dead_battery;

  // one timebase for all three intervals
  tick_divider #(.TICK_CYCLES(TICK_CYCLES_P)) u_tick (
    .clk_in(mclk_in),
    .rst_n_in(rst_n),
    .tick_out(tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    case (state)
      ST_WAIT_OK: begin
        if (ok_rise) next_state = ST_POR;
      end
      ST_POR: begin
        if (dead_low) next_state = ST_DEAD;
        else if (span_done(tick_count, POR_TICKS, tick)) next_state = ST_RUN;
      end
      ST_RUN: begin
        if (dead_low) next_state = ST_DEAD;
        else if (!sense_sync.battery_ok) next_state = ST_MR_DEBOUNCE;
      end
      ST_MR_DEBOUNCE: begin
        if (dead_low) next_state = ST_DEAD;
        else if (sense_sync.battery_ok) next_state = ST_RUN;
        else if (span_done(tick_count, DEB_TICKS, tick)) next_state = ST_MR_PULSE;
      end
      ST_MR_PULSE: begin
        // a switch still held keeps reset asserted past the minimum
        if (dead_low) next_state = ST_DEAD;
        else if (span_done(tick_count, MR_TICKS, tick) && sense_sync.battery_ok) begin
          next_state = ST_RUN;
        end
      end
      ST_DEAD: begin
        // only a fresh rise of battery-ok, i.e. a replaced battery, leaves here
        if (ok_rise) next_state = ST_POR;
      end
      default: next_state = ST_WAIT_OK;
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_WAIT_OK;
    end else begin
      state <= next_state;
    end
  end

  // interval counter restarts on every state change and saturates
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      tick_count <= 10'h000;
    end else if (next_state != state) begin
      tick_count <= 10'h000;
    end else if (tick && tick_count != CNT_MAX) begin
      tick_count <= tick_count + 10'h001;
    end
  end

  // a dead battery seen in the clearing cycle still wins
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      power_off_latch <= 1'b0;
    end else if (dead_low) begin
      power_off_latch <= 1'b1;
    end else if (next_state == ST_POR && state != ST_POR) begin
      power_off_latch <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      sys_reset_oe_out <= 1'b1;
    end else begin
      sys_reset_oe_out <= !(next_state == ST_RUN || next_state == ST_MR_DEBOUNCE);
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      low_battery_alert_oe_out <= 1'b0;
      power_off_flag_oe_out <= 1'b0;
    end else begin
      low_battery_alert_oe_out <= !sense_sync.low_battery;
      power_off_flag_oe_out <= dead_low || power_off_latch;
    end
  end

  // pins only ever pull low; release is a floating pin
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      pin_low <= 1'b0;
    end else begin
      pin_low <= 1'b0;
    end
  end
  assign sys_reset_n_out = pin_low;
  assign low_battery_alert_n_out = pin_low;
  assign power_off_flag_n_out = pin_low;

  ////////////////////////////////////////////////////////////////////////////////
  logic [CNT_W:0] hold_ticks;

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      hold_ticks <= 11'h000;
    end else if (next_state != state && (next_state == ST_POR || next_state == ST_MR_PULSE)) begin
      hold_ticks <= 11'h000;
    end else if (tick && hold_ticks != 11'h7FF) begin
      hold_ticks <= hold_ticks + 11'h001;
    end
  end

  a_por_width: assert property (@(posedge mclk_in) disable iff (!rst_n)
    ($fell(sys_reset_oe_out) && $past(state) == ST_POR) |-> hold_ticks >= POR_TICKS)
    else $error("reset released before power-on interval");

  a_alert_follow: assert property (@(posedge mclk_in) disable iff (!rst_n)
    low_battery_alert_oe_out == !$past(sense_sync.low_battery))
    else $error("alert did not follow comparator");

  a_dead_latch: assert property (@(posedge mclk_in) disable iff (!rst_n)
    dead_low |-> ##1 (power_off_flag_oe_out && sys_reset_oe_out))
    else $error("dead battery did not assert reset and flag");

  a_flag_clear: assert property (@(posedge mclk_in) disable iff (!rst_n)
    $fell(power_off_flag_oe_out) |-> $past(state) == ST_POR)
    else $error("power-off flag cleared outside a new reset cycle");

  a_mr_width: assert property (@(posedge mclk_in) disable iff (!rst_n)
    ($fell(sys_reset_oe_out) && $past(state) == ST_MR_PULSE) |-> hold_ticks >= MR_TICKS)
    else $error("manual reset pulse too short");

  a_pins_low: assert property (@(posedge mclk_in) disable iff (!rst_n)
    !sys_reset_n_out && !low_battery_alert_n_out && !power_off_flag_n_out)
    else $error("open-drain pin driven high");

  a_ratio_fixed: assert property (@(posedge mclk_in) disable iff (!rst_n)
    POR_TICKS == 10'(32 * DEB_TICKS) && MR_TICKS == 10'(8 * DEB_TICKS))
    else $error("interval ratio broken");

  a_debounce_len: assert property (@(posedge mclk_in) disable iff (!rst_n)
    (state == ST_MR_PULSE && $past(state) == ST_MR_DEBOUNCE)
      |-> ($past(tick) && $past(tick_count) == DEB_TICKS - 10'h001))
    else $error("manual reset accepted before debounce");

  a_bounce_abort: assert property (@(posedge mclk_in) disable iff (!rst_n)
    (state == ST_MR_DEBOUNCE && sense_sync.battery_ok && !dead_low) |-> ##1 state == ST_RUN)
    else $error("bounce not rejected");

  a_timing_range: assert property (@(posedge mclk_in) disable iff (!rst_n)
    MR_MS >= 175 && MR_MS <= 300 && DEBOUNCE_MS >= 22 && DEBOUNCE_MS <= 38)
    else $error("interval outside allowed range");

  c_por_done: cover property (@(posedge mclk_in) disable iff (!rst_n)
    state == ST_POR ##1 state == ST_RUN);
  c_mr_done: cover property (@(posedge mclk_in) disable iff (!rst_n)
    state == ST_MR_PULSE ##1 state == ST_RUN);
  c_dead: cover property (@(posedge mclk_in) disable iff (!rst_n)
    state == ST_RUN ##1 state == ST_DEAD);
  c_bounce: cover property (@(posedge mclk_in) disable iff (!rst_n)
    state == ST_MR_DEBOUNCE ##1 state == ST_RUN);

endmodule
`default_nettype wire

// >>> sim/host_model.sv
// Purpose: supervised host side of the three open-drain flag lines
// Assumes: every flag line has a pull-up at the host
// Notes: a released line reads high, never the last driven value
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic rst_n_in,
  input wire logic rst_oe_in,
  input wire logic alert_n_in,
  input wire logic alert_oe_in,
  input wire logic off_flag_n_in,
  input wire logic off_flag_oe_in,
  output logic rst_pin_out,
  output logic alert_pin_out,
  output logic off_flag_pin_out,
  output logic high_power_ok_out
);
  // pull-up wins whenever the pin is not driven
  assign rst_pin_out = rst_oe_in ? rst_n_in : 1'b1;
  assign alert_pin_out = alert_oe_in ? alert_n_in : 1'b1;
  assign off_flag_pin_out = off_flag_oe_in ? off_flag_n_in : 1'b1;
  // advisory only: the host holds back heavy work while alerted or in reset
  assign high_power_ok_out = alert_pin_out & rst_pin_out;
endmodule
`default_nettype wire

// >>> sim/testbench.sv
// Purpose: self-checking bench of the battery state supervisor logic
// Assumes: tick shortened to T clocks, all intervals scale with it
// Notes: pins are read through the host model pull-ups
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int T = 4;
  logic mclk, arst_n, ok, low, dead;
  logic rn, roe, an, aoe, pn, poe, rst_pin, alert_pin, off_pin, hp_ok;
  int n_fail = 0;
  int checks = 0;
  int n;

  battery_state_supervisor_logic #(.TICK_CYCLES_P(T)) u_battery_state_supervisor_logic (
    .mclk_in(mclk), .arst_n_in(arst_n), .battery_ok_sense_manual_reset_in(ok),
    .low_battery_sense_in(low), .dead_battery_sense_in(dead),
    .sys_reset_n_out(rn), .sys_reset_oe_out(roe), .low_battery_alert_n_out(an),
    .low_battery_alert_oe_out(aoe), .power_off_flag_n_out(pn), .power_off_flag_oe_out(poe));
  host_model u_host_model (
    .rst_n_in(rn), .rst_oe_in(roe), .alert_n_in(an), .alert_oe_in(aoe),
    .off_flag_n_in(pn), .off_flag_oe_in(poe), .rst_pin_out(rst_pin),
    .alert_pin_out(alert_pin), .off_flag_pin_out(off_pin), .high_power_ok_out(hp_ok));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check_bit(input string name, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic check_range(input string name, input int lo, input int hi, input int got);
    checks++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("wrong value %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask
  // counts cycles until the reset line reads lvl; a spent bound ends the run
  task automatic wait_rst(input logic lvl, input int lim, output int cnt);
    cnt = 0;
    while (rst_pin !== lvl) begin
      @(posedge mclk);
      #1;
      cnt++;
      if (cnt > lim) begin
        n_fail++;
        $display("wrong value reset wait expected done seen timeout");
        summarize();
      end
    end
  endtask
  task automatic drive(input logic o, input logic l, input logic d, input int hold);
    @(posedge mclk);
    ok <= o;
    low <= l;
    dead <= d;
    repeat (hold) @(posedge mclk);
    #1;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic power_on();
    wait_rst(1'b1, 900 * T, n);
    check_range("power on length", 799 * T, 800 * T + 8, n);
    check_bit("power-off flag after power on", 1'b1, off_pin);
  endtask
  task automatic low_alert();
    drive(1'b1, 1'b0, 1'b1, 5);
    check_bit("alert asserted", 1'b0, alert_pin);
    check_bit("reset during alert", 1'b1, rst_pin);
    check_bit("host high power while alerted", 1'b0, hp_ok);
    drive(1'b1, 1'b1, 1'b1, 5);
    check_bit("alert released", 1'b1, alert_pin);
    check_bit("host high power after alert", 1'b1, hp_ok);
  endtask
  task automatic short_press();
    int lows;
    lows = 0;
    drive(1'b0, 1'b1, 1'b1, 0);
    repeat (20 * T) begin
      @(posedge mclk);
      #1;
      if (rst_pin !== 1'b1) lows++;
    end
    drive(1'b1, 1'b1, 1'b1, 10);
    check_range("short press reset cycles", 0, 0, lows);
  endtask
  task automatic manual_reset();
    drive(1'b0, 1'b1, 1'b1, 0);
    wait_rst(1'b0, 30 * T, n);
    check_range("debounce length", 24 * T, 25 * T + 4, n);
    drive(1'b1, 1'b1, 1'b1, 0);
    wait_rst(1'b1, 210 * T, n);
    check_range("manual pulse length", 199 * T - 1, 200 * T + 4, n);
  endtask
  task automatic dead_battery();
    drive(1'b1, 1'b1, 1'b0, 6);
    check_bit("power-off flag on dead", 1'b0, off_pin);
    check_bit("reset on dead", 1'b0, rst_pin);
    drive(1'b1, 1'b1, 1'b1, 40);
    check_bit("power-off flag latched", 1'b0, off_pin);
    check_bit("reset latched", 1'b0, rst_pin);
    drive(1'b0, 1'b1, 1'b1, 5);
    drive(1'b1, 1'b1, 1'b1, 0);
    wait_rst(1'b1, 900 * T, n);
    check_range("restart length", 799 * T, 800 * T + 8, n);
    check_bit("power-off flag cleared", 1'b1, off_pin);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    arst_n = 1'b0;
    ok = 1'b1;
    low = 1'b1;
    dead = 1'b1;
    @(posedge mclk);
    #1;
    check_bit("reset held in reset", 1'b0, rst_pin);
    @(posedge mclk);
    arst_n <= 1'b1;
    power_on();
    low_alert();
    short_press();
    manual_reset();
    dead_battery();
    summarize();
  end
endmodule
`default_nettype wire
